// [verilog/smic_pkg.sv]
// Purpose: constants shared by the slave-mode interrupt controller
// Assumes: 16-bit registers inside the peripheral control block, byte offsets
// Notes:   six source slots, slot 1 unused
package smic_pkg;

  localparam int unsigned NUM_SRC   = 6;
  localparam int unsigned LVL_W     = 3;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 8;

  // register offsets
  localparam logic [7:0] OFS_VECTOR_BASE  = 8'h20;
  localparam logic [7:0] OFS_END_SERVICE  = 8'h22;
  localparam logic [7:0] OFS_BLOCK_FLAGS  = 8'h28;
  localparam logic [7:0] OFS_THRESHOLD    = 8'h2a;
  localparam logic [7:0] OFS_ACTIVE_FLAGS = 8'h2c;
  localparam logic [7:0] OFS_PENDING      = 8'h2e;
  localparam logic [7:0] OFS_CTL_BASE     = 8'h30;
  localparam logic [7:0] OFS_EXT_CTL      = 8'h3c;
  localparam logic [7:0] OFS_RELOCATION   = 8'hfe;

  // field positions
  localparam int unsigned VEC_LSB        = 3;
  localparam int unsigned VEC_W          = 5;
  localparam int unsigned CTL_MSK_BIT    = 3;
  localparam int unsigned EXT_TRIG_BIT   = 4;
  localparam int unsigned EXT_CASC_BIT   = 5;
  localparam int unsigned EXT_SNEST_BIT  = 6;
  localparam int unsigned REL_SLAVE_BIT  = 14;
  localparam int unsigned RSVD_SLOT      = 1;

  // reset values
  localparam logic [2:0]  LVL_RST        = 3'h7;
  localparam logic        MSK_RST        = 1'b1;
  localparam logic [2:0]  THRESH_RST     = 3'h7;
  localparam logic [4:0]  VEC_RST        = 5'h00;
  localparam logic [6:0]  EXT_CTL_RST    = 7'h0f;
  localparam logic [5:0]  FLAGS_RST      = 6'h00;

  // acknowledge pulse width
  localparam int unsigned ACK_LOW_NS     = 20;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned ACK_LOW_CYC    =
    (ACK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SMIC_ACK_IDLE = 2'b00,
    SMIC_ACK_LOW  = 2'b01
  } smic_ack_state_t;

endpackage

// [verilog/smic_sync2.sv]
// Purpose: two-flop synchroniser for a pin input
// Assumes: asynchronous input, one destination clock
// Notes:   first flop feeds only the second
`timescale 1ns/10ps
module smic_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      sync_out
);

  logic meta_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [verilog/smic_resolver.sv]
// Purpose: pick the valid source with the numerically lowest level
// Assumes: levels packed three bits per source
// Notes:   ties go to the lower source index
`timescale 1ns/10ps
module smic_resolver #(
  parameter int unsigned N = 6
) (
  input  wire logic [N-1:0]   valid,
  input  wire logic [3*N-1:0] levels,
  output logic                any,
  output logic [2:0]          win_idx,
  output logic [2:0]          win_lvl
);

  always_comb begin
    any     = 1'b0;
    win_idx = 3'h0;
    win_lvl = 3'h7;
    for (int i = 0; i < N; i++) begin
      if (valid[i] && (!any || (levels[3*i +: 3] < win_lvl))) begin
        any     = 1'b1;
        win_idx = 3'(i);
        win_lvl = levels[3*i +: 3];
      end
    end
  end

endmodule

// [verilog/smic_top.sv]
// Purpose: interrupt controller in cascaded slave mode under a master controller
// Assumes: internal requests and cpu strobes on mclk; pins are asynchronous
// Notes:   slots 0 timer0, 2 dma0, 3 dma1, 4 timer1, 5 timer2
`timescale 1ns/10ps
module smic_top
  import smic_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic [smic_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [smic_pkg::DATA_W-1:0]  reg_wdata,
  output logic      [smic_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [2:0]                   tmr_req,
  input  wire logic [1:0]                   dma_req,
  input  wire logic                         ext_int_pin,
  input  wire logic                         slave_select_pin_n,
  output logic                              ack_output_pin_n,
  output logic                              slave_request_output_pin,
  output logic                              cpu_int_req,
  input  wire logic                         cpu_master_ack_input,
  output logic      [7:0]                   vec_out,
  output logic                              vec_valid,
  output logic                              slave_mode
);
  import smic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [2:0]        lvl_reg [NUM_SRC];
  logic [NUM_SRC-1:0] msk_reg;
  logic [NUM_SRC-1:0] isr_reg;
  logic [NUM_SRC-1:0] irr_reg;
  logic [2:0]        thresh_reg;
  logic [4:0]        vec_base_reg;
  logic [6:0]        ext_ctl_reg;
  logic              slave_reg;
  logic [NUM_SRC-1:0] req_now;
  logic [NUM_SRC-1:0] req_prev_reg;
  logic [NUM_SRC-1:0] req_rise;
  logic [NUM_SRC-1:0] slot_used;
  logic              ext_int_sync;
  logic              sel_n_sync;
  smic_ack_state_t   ack_state_reg;
  smic_ack_state_t   ack_state_next;
  logic [1:0]        ack_cnt_reg;
  logic [3*NUM_SRC-1:0] lvl_flat;
  logic [NUM_SRC-1:0] cand;
  logic              cand_any;
  logic [2:0]        cand_idx;
  logic [2:0]        cand_lvl;
  logic              isr_any;
  logic [2:0]        isr_lvl;
  logic              ack_take;
  logic [NUM_SRC-1:0] ack_set;
  logic [NUM_SRC-1:0] eoi_clr;
  logic              wr_ctl;
  logic [2:0]        ctl_idx;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  smic_sync2 #(.RST_VAL(1'b0)) u_sync_int (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pin_in   (ext_int_pin),
    .sync_out (ext_int_sync)
  );

  smic_sync2 #(.RST_VAL(1'b1)) u_sync_sel (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pin_in   (slave_select_pin_n),
    .sync_out (sel_n_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // source slots and request edges
  assign slot_used = 6'b111101;
  assign req_now   = {tmr_req[2], tmr_req[1], dma_req[1], dma_req[0], 1'b0, tmr_req[0]};
  assign req_rise  = req_now & ~req_prev_reg & slot_used;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_prev_reg <= FLAGS_RST;
    end else begin
      req_prev_reg <= req_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority resolution
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl_flat[3*i +: 3] = lvl_reg[i];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      cand[i] = irr_reg[i] && !msk_reg[i] && slot_used[i]
                && (lvl_reg[i] <= thresh_reg)
                && (!isr_any || (lvl_reg[i] <= isr_lvl));
    end
  end

  smic_resolver #(.N(NUM_SRC)) u_pend (
    .valid   (cand),
    .levels  (lvl_flat),
    .any     (cand_any),
    .win_idx (cand_idx),
    .win_lvl (cand_lvl)
  );

  smic_resolver #(.N(NUM_SRC)) u_serv (
    .valid   (isr_reg),
    .levels  (lvl_flat),
    .any     (isr_any),
    .win_idx (),
    .win_lvl (isr_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request outputs
  assign slave_request_output_pin = slave_reg && cand_any;
  assign cpu_int_req = slave_reg ? ext_int_sync : cand_any;
  assign slave_mode  = slave_reg;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge handling
  assign ack_take = cpu_master_ack_input && cand_any && (!slave_reg || !sel_n_sync);

  always_comb begin
    ack_set = '0;
    if (ack_take) begin
      ack_set[cand_idx] = 1'b1;
    end
  end

  always_comb begin
    ack_state_next = ack_state_reg;
    case (ack_state_reg)
      SMIC_ACK_IDLE: begin
        if (cpu_master_ack_input && slave_reg) begin
          ack_state_next = SMIC_ACK_LOW;
        end
      end
      SMIC_ACK_LOW: begin
        if (ack_cnt_reg == 2'(ACK_LOW_CYC - 1)) begin
          ack_state_next = SMIC_ACK_IDLE;
        end
      end
      default: ack_state_next = SMIC_ACK_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_state_reg <= SMIC_ACK_IDLE;
      ack_cnt_reg   <= 2'h0;
    end else begin
      ack_state_reg <= ack_state_next;
      if (ack_state_reg == SMIC_ACK_LOW) begin
        ack_cnt_reg <= ack_cnt_reg + 2'h1;
      end else begin
        ack_cnt_reg <= 2'h0;
      end
    end
  end

  assign ack_output_pin_n = (ack_state_reg != SMIC_ACK_LOW);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vec_out   <= 8'h00;
      vec_valid <= 1'b0;
    end else begin
      vec_valid <= ack_take;
      if (ack_take) begin
        vec_out <= {vec_base_reg, cand_lvl};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request and service flags
  always_comb begin
    eoi_clr = '0;
    if (reg_wr && reg_addr == OFS_END_SERVICE) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        eoi_clr[i] = (lvl_reg[i] == reg_wdata[2:0]);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irr_reg <= FLAGS_RST;
    end else begin
      irr_reg <= (irr_reg & ~ack_set) | req_rise;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      isr_reg <= FLAGS_RST;
    end else if (reg_wr && reg_addr == OFS_ACTIVE_FLAGS) begin
      isr_reg <= (reg_wdata[NUM_SRC-1:0] & slot_used) | ack_set;
    end else begin
      isr_reg <= (isr_reg & ~eoi_clr) | ack_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control words and masks
  assign wr_ctl  = reg_wr && reg_addr >= OFS_CTL_BASE
                   && reg_addr < OFS_CTL_BASE + 8'(2 * NUM_SRC) && !reg_addr[0];
  assign ctl_idx = 3'((reg_addr - OFS_CTL_BASE) >> 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        lvl_reg[i] <= LVL_RST;
      end
    end else if (wr_ctl && slot_used[ctl_idx]) begin
      lvl_reg[ctl_idx] <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      msk_reg <= {NUM_SRC{MSK_RST}};
    end else if (reg_wr && reg_addr == OFS_BLOCK_FLAGS) begin
      msk_reg <= reg_wdata[NUM_SRC-1:0] | ~slot_used;
    end else if (wr_ctl && slot_used[ctl_idx]) begin
      msk_reg[ctl_idx] <= reg_wdata[CTL_MSK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector, threshold, external control, mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vec_base_reg <= VEC_RST;
    end else if (reg_wr && reg_addr == OFS_VECTOR_BASE) begin
      vec_base_reg <= reg_wdata[VEC_LSB +: VEC_W];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_reg <= THRESH_RST;
    end else if (reg_wr && reg_addr == OFS_THRESHOLD) begin
      thresh_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ctl_reg <= EXT_CTL_RST;
    end else if (reg_wr && reg_addr == OFS_EXT_CTL) begin
      ext_ctl_reg <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slave_reg <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_RELOCATION) begin
      slave_reg <= reg_wdata[REL_SLAVE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      if (wr_ctl || (reg_addr >= OFS_CTL_BASE
          && reg_addr < OFS_CTL_BASE + 8'(2 * NUM_SRC) && !reg_addr[0])) begin
        if (slot_used[ctl_idx]) begin
          reg_rdata <= {12'h000, msk_reg[ctl_idx], lvl_reg[ctl_idx]};
        end
      end else begin
        case (reg_addr)
          OFS_VECTOR_BASE:  reg_rdata <= {8'h00, vec_base_reg, 3'h0};
          OFS_BLOCK_FLAGS:  reg_rdata <= {10'h000, msk_reg};
          OFS_THRESHOLD:    reg_rdata <= {13'h0000, thresh_reg};
          OFS_ACTIVE_FLAGS: reg_rdata <= {10'h000, isr_reg};
          OFS_PENDING:      reg_rdata <= {10'h000, irr_reg};
          OFS_EXT_CTL:      reg_rdata <= {9'h000, ext_ctl_reg};
          OFS_RELOCATION:   reg_rdata <= {1'b0, slave_reg, 14'h0000};
          default:          reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// [tb/smic_properties.sv]
// Purpose: port-level checker for the slave-mode interrupt controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to smic_top from the testbench top file
`timescale 1ns/10ps
module smic_properties
  import smic_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0]  tmr_req,
  input wire logic [1:0]  dma_req,
  input wire logic        ext_int_pin,
  input wire logic        slave_select_pin_n,
  input wire logic        ack_output_pin_n,
  input wire logic        slave_request_output_pin,
  input wire logic        cpu_int_req,
  input wire logic        cpu_master_ack_input,
  input wire logic [7:0]  vec_out,
  input wire logic        vec_valid,
  input wire logic        slave_mode
);
  logic [4:0] base_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // shadow of the programmed upper vector bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= VEC_RST;
    end else if (reg_wr && reg_addr == OFS_VECTOR_BASE) begin
      base_reg <= reg_wdata[7:3];
    end
  end

  ////////////////////////////////////////////////////////////////
  sequence s_ack_taken;
    slave_mode && cpu_master_ack_input && ack_output_pin_n;
  endsequence
  sequence s_ack_pulse;
    !ack_output_pin_n [*2] ##1 ack_output_pin_n;
  endsequence

  a_ack_pulse_len:
    assert property (s_ack_taken |=> s_ack_pulse) else $error("ack pulse width wrong");
  a_ack_quiet_norm:
    assert property (!slave_mode [*3] |-> ack_output_pin_n) else $error("ack in normal mode");
  a_sreq_normal:
    assert property (!slave_mode |-> !slave_request_output_pin) else $error("slave request out");
  a_int_follows_pin:
    assert property (slave_mode |-> cpu_int_req == $past(ext_int_pin, 2))
      else $error("cpu interrupt not from pin");
  a_unsel_no_vec:
    assert property (slave_mode && cpu_master_ack_input && $past(slave_select_pin_n, 2) |=> !vec_valid)
      else $error("vector while not selected");
  a_vec_needs_ack:
    assert property (vec_valid |-> $past(cpu_master_ack_input)) else $error("vector without ack");
  a_vec_held:
    assert property (!vec_valid |-> $stable(vec_out)) else $error("vector changed");
  a_vec_base_bits:
    assert property (vec_valid |-> vec_out[7:3] == $past(base_reg))
      else $error("vector base wrong");
  a_eos_reads_zero:
    assert property (reg_rd && reg_addr == OFS_END_SERVICE |=> reg_rdata == 16'h0000)
      else $error("end of service readable");
  a_mode_from_reloc:
    assert property (reg_wr && reg_addr == OFS_RELOCATION |=> slave_mode == $past(reg_wdata[14]))
      else $error("mode not from relocation");
  a_mode_steady:
    assert property (!(reg_wr && reg_addr == OFS_RELOCATION) |=> $stable(slave_mode))
      else $error("mode changed alone");
endmodule

// [tb/smic_master_model.sv]
// Purpose: external master controller and cascade decode
// Assumes: master forwards slave request to the cpu interrupt pin
// Notes:   casc_hit chooses whether the cascade lines address this slave
`timescale 1ns/10ps
module smic_master_model #(
  parameter logic [2:0] SLAVE_ID = 3'h3
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic casc_hit,
  input  wire logic slave_request_output_pin,
  input  wire logic ack_output_pin_n,
  output logic      ext_int_pin,
  output logic      slave_select_pin_n,
  output logic      ack_ready
);
  logic [2:0] cascade_address_lines;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_int_pin           <= 1'b0;
      cascade_address_lines <= ~SLAVE_ID;
    end else begin
      ext_int_pin           <= slave_request_output_pin;
      cascade_address_lines <= casc_hit ? SLAVE_ID : ~SLAVE_ID;
    end
  end
  // outside decode of the cascade lines
  assign slave_select_pin_n = (cascade_address_lines != SLAVE_ID);
  // ready for the acknowledge cycle follows the slave acknowledge output pin
  assign ack_ready = !ack_output_pin_n;
endmodule

// [tb/smic_top_tb.sv]
// Purpose: self-checking bench for the slave-mode interrupt controller
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   master model closes the loop between request and cpu pins
`timescale 1ns/10ps
module smic_top_tb;
  import smic_pkg::*;
  localparam logic [7:0]  RA [9] = '{OFS_BLOCK_FLAGS, OFS_THRESHOLD, OFS_ACTIVE_FLAGS,
    OFS_PENDING, OFS_CTL_BASE, 8'h3a, OFS_EXT_CTL, OFS_END_SERVICE, 8'h32};
  localparam logic [15:0] RV [9] = '{16'h003f, 16'h0007, 16'h0000, 16'h0000, 16'h000f,
    16'h000f, 16'h000f, 16'h0000, 16'h0000};
  logic        mclk, rst_n, reg_wr, reg_rd, cpu_master_ack_input, casc_hit, ext_int_pin, sel_n, ack_n;
  logic        sreq, cpu_int_req, vec_valid, slave_mode;
  logic [7:0]  reg_addr, vec_out;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  tmr_req;
  logic [1:0]  dma_req;
  int          failures, comparisons;

  always #5 mclk = ~mclk;

  smic_top u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tmr_req(tmr_req),
    .dma_req(dma_req), .ext_int_pin(ext_int_pin), .slave_select_pin_n(sel_n),
    .ack_output_pin_n(ack_n), .slave_request_output_pin(sreq), .cpu_int_req(cpu_int_req),
    .cpu_master_ack_input(cpu_master_ack_input), .vec_out(vec_out), .vec_valid(vec_valid), .slave_mode(slave_mode));
  smic_master_model u_master (.mclk(mclk), .rst_n(rst_n), .casc_hit(casc_hit),
    .slave_request_output_pin(sreq), .ack_output_pin_n(ack_n), .ext_int_pin(ext_int_pin),
    .slave_select_pin_n(sel_n), .ack_ready());

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    tick(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    tick(1);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask
  task automatic raise(input logic [2:0] t, input logic [1:0] d);
    tick(1);
    tmr_req = t;
    dma_req = d;
    tick(1);
    tmr_req = 3'h0;
    dma_req = 2'h0;
    tick(4);
  endtask
  task automatic ack(input logic hit, input logic [7:0] v);
    tick(1);
    cpu_master_ack_input = 1'b1;
    tick(1);
    cpu_master_ack_input = 1'b0;
    check({15'h0000, vec_valid}, {15'h0000, hit});
    if (hit) check({8'h00, vec_out}, {8'h00, v});
    check({15'h0000, ack_n}, 16'h0000);
    tick(1);
    check({15'h0000, ack_n}, 16'h0000);
    tick(1);
    check({15'h0000, ack_n}, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset_defaults;
    check({15'h0000, slave_mode}, 16'h0000);
    for (int i = 0; i < 9; i++) rdc(RA[i], RV[i]);
    rdc(8'h40, 16'h0000);
  endtask
  task automatic t_program;
    wr(OFS_RELOCATION, 16'h4000);
    check({15'h0000, slave_mode}, 16'h0001);
    for (int i = 0; i < 6; i++) if (i != 1) wr(OFS_CTL_BASE + 8'(2 * i), 16'(i));
    rdc(OFS_BLOCK_FLAGS, 16'h0002);
    wr(OFS_BLOCK_FLAGS, 16'h0006);
    rdc(8'h34, 16'h000a);
    rdc(8'h38, 16'h0004);
    wr(OFS_BLOCK_FLAGS, 16'h0002);
    wr(OFS_VECTOR_BASE, 16'h00a8);
    rdc(OFS_VECTOR_BASE, 16'h00a8);
    wr(OFS_ACTIVE_FLAGS, 16'h003f);
    rdc(OFS_ACTIVE_FLAGS, 16'h003d);
    wr(OFS_ACTIVE_FLAGS, 16'h0000);
    rdc(OFS_ACTIVE_FLAGS, 16'h0000);
  endtask
  task automatic t_nesting;
    raise(3'h2, 2'h2);
    rdc(OFS_PENDING, 16'h0018);
    check({14'h0000, cpu_int_req, sreq}, 16'h0003);
    ack(1'b1, 8'hab);
    rdc(OFS_ACTIVE_FLAGS, 16'h0008);
    rdc(OFS_PENDING, 16'h0010);
    ack(1'b0, 8'h00);
    raise(3'h0, 2'h1);
    ack(1'b1, 8'haa);
    rdc(OFS_ACTIVE_FLAGS, 16'h000c);
    wr(OFS_END_SERVICE, 16'h0002);
    rdc(OFS_ACTIVE_FLAGS, 16'h0008);
    wr(OFS_END_SERVICE, 16'h0003);
    ack(1'b1, 8'hac);
    wr(OFS_END_SERVICE, 16'h0004);
    rdc(OFS_ACTIVE_FLAGS, 16'h0000);
  endtask
  task automatic t_threshold;
    wr(OFS_THRESHOLD, 16'h0003);
    raise(3'h4, 2'h0);
    ack(1'b0, 8'h00);
    wr(OFS_THRESHOLD, 16'h0005);
    wr(OFS_VECTOR_BASE, 16'h0050);
    ack(1'b1, 8'h55);
    wr(OFS_END_SERVICE, 16'h0005);
    wr(OFS_THRESHOLD, 16'h0007);
  endtask
  task automatic t_select;
    casc_hit = 1'b0;
    raise(3'h1, 2'h0);
    ack(1'b0, 8'h00);
    casc_hit = 1'b1;
    tick(4);
    ack(1'b1, 8'h50);
    wr(OFS_END_SERVICE, 16'h0000);
    rdc(OFS_ACTIVE_FLAGS, 16'h0000);
    wr(OFS_RELOCATION, 16'h0000);
    check({14'h0000, slave_mode, sreq}, 16'h0000);
    // normal mode: internal pending drives the cpu, no acknowledge pin activity
    raise(3'h1, 2'h0);
    check({14'h0000, cpu_int_req, sreq}, 16'h0002);
    cpu_master_ack_input = 1'b1;
    tick(1);
    cpu_master_ack_input = 1'b0;
    check({7'h00, vec_valid, vec_out}, 16'h0150);
    check({15'h0000, ack_n}, 16'h0001);
    tick(1);
    check({15'h0000, ack_n}, 16'h0001);
    wr(OFS_END_SERVICE, 16'h0000);
    rdc(OFS_ACTIVE_FLAGS, 16'h0000);
  endtask

  task automatic end_of_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  initial begin
    {mclk, reg_wr, reg_rd, cpu_master_ack_input, rst_n} = 5'h00;
    {reg_addr, reg_wdata, tmr_req, dma_req} = 29'h00000000;
    casc_hit = 1'b1;
    failures = 0;
    comparisons = 0;
    tick(12);
    rst_n = 1'b1;
    tick(2);
    t_reset_defaults();
    t_program();
    t_nesting();
    t_threshold();
    t_select();
    end_of_test();
  end
endmodule

bind smic_top smic_properties u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tmr_req(tmr_req), .dma_req(dma_req), .ext_int_pin(ext_int_pin),
  .slave_select_pin_n(slave_select_pin_n), .ack_output_pin_n(ack_output_pin_n),
  .slave_request_output_pin(slave_request_output_pin), .cpu_int_req(cpu_int_req),
  .cpu_master_ack_input(cpu_master_ack_input), .vec_out(vec_out), .vec_valid(vec_valid), .slave_mode(slave_mode));
